// ===== isp_map.svh
// Constants for the ISP pin-control and security block: instruction codes,
// clamp codes, flag bit positions and timing figures.
// Assumes inclusion by isp_io_control.sv and by its testbench; holds definitions only.
`ifndef ISP_MAP_SVH
`define ISP_MAP_SVH

`define IR_W 4
`define IR_CAPTURE 4'h1
`define INS_IDCODE 4'h0
`define INS_ENTER 4'h1
`define INS_CLAMP 4'h2
`define INS_EXIT 4'h3
`define INS_ERASE_CFG 4'h4
`define INS_ERASE_UFM 4'h5
`define INS_ADDRESS 4'h6
`define INS_PROGRAM 4'h7
`define INS_VERIFY 4'h8
`define INS_SECURE 4'h9
`define INS_DONE 4'ha
`define INS_RECONFIG 4'hb
`define INS_ENTER_RT 4'hc
`define INS_BYPASS 4'hf

`define CLAMP_HOLD 2'h0
`define CLAMP_HIGH 2'h1
`define CLAMP_LOW 2'h2
`define CLAMP_TRI 2'h3

`define FLAG_DONE_BIT 0
`define FLAG_SECURE_BIT 1

`define MCLK_MHZ 100
`define CONFIG_TIME_US 100
// Identification value is arbitrary.
`define DEVICE_ID 32'h0000_5a5a

`endif

// ===== isp_pkg.sv
// Types shared by the ISP pin-control block: link controller and boot states.
// Assumes nothing of its surroundings.
package isp_pkg;

  typedef enum logic [3:0] {
    TAP_RESET = 4'h0, TAP_IDLE = 4'h1, TAP_SEL_DR = 4'h2, TAP_CAP_DR = 4'h3,
    TAP_SH_DR = 4'h4, TAP_EX1_DR = 4'h5, TAP_PA_DR = 4'h6, TAP_EX2_DR = 4'h7,
    TAP_UPD_DR = 4'h8, TAP_SEL_IR = 4'h9, TAP_CAP_IR = 4'ha, TAP_SH_IR = 4'hb,
    TAP_EX1_IR = 4'hc, TAP_PA_IR = 4'hd, TAP_EX2_IR = 4'he, TAP_UPD_IR = 4'hf
  } tap_state_e;

  typedef enum logic [2:0] {
    BOOT_OFF = 3'h0,
    BOOT_IMG = 3'h1,
    BOOT_FLAG = 3'h2,
    BOOT_WAIT = 3'h3,
    BOOT_RUN = 3'h4
  } boot_state_e;

endpackage

// ===== flash_store.sv
// Flash array model holding the config and user regions in one word store.
// Assumes one access per cycle from the owning controller.
`timescale 1ns/1ps
module flash_store #(
  parameter int AW = 6,
  parameter int DW = 16
)(
  input wire logic clk, // Main clock.
  input wire logic rst_n, // Asynchronous reset, active low.
  input wire logic we, // Write strobe.
  input wire logic [AW-1:0] addr, // Word address.
  input wire logic [DW-1:0] wdata, // Write data.
  output logic [DW-1:0] rdata // Read data, one cycle after address.
);

  logic [DW-1:0] mem [0:(1<<AW)-1];

  initial
  begin
    if (AW < 2 || DW < 2)
      $error("flash_store: AW and DW must be at least 2");
  end

  always_ff @(posedge clk)
  begin
    if (we)
      mem[addr] <= wdata;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      rdata <= '0;
    else
      rdata <= mem[addr];
  end

endmodule

// ===== isp_io_control.sv
// ISP pin control, flash loader and readback security behind a JTAG-style link.
// Assumes TCK/TMS/TDI and pins are asynchronous; user logic runs on MCLK.
//
// Operation
// R1: User and config regions program independently.
// R2: Host programs both regions by default.
// R3: Plain ISP entry tri-states pins with pull-ups.
// R4: Clamp holds, drives high, low or tri-states.
// R5: Held input pins stay tri-stated.
// R6: Clamp setting is kept per pin.
// R7: Real-time mode keeps user design running.
// R8: New image loads only at next boot.
// R9: Command sequence reloads configuration immediately.
// R10: Pins tri-stated with pull-ups during reload.
// R11: Security bit blocks config region readback.
// R12: Only config erase clears security bit.
// R13: Volatile configuration is never read back.
// R14: User region ignores the security bit.
// R15: No pin drives until powered and configured.
// R16: No pin drives until complete flag set. The clamp still drives pins while the complete flag is clear.
// R17: Host waits erase time in idle.
// R18: Host waits program pulse in idle.
// R19: Host follows enter-id-erase-program-verify-exit order.
// R20: Configuration time is a design parameter.
`include "isp_map.svh"
`timescale 1ns/1ps
module isp_io_control
  import isp_pkg::*;
#(
  parameter int N_PINS = 8,
  parameter int AW = 6,
  parameter int DW = 16,
  parameter int CONFIG_CYCLES = `CONFIG_TIME_US * `MCLK_MHZ // R20
)(
  input wire logic MCLK, // 100 MHz clock.
  input wire logic RST_N, // Asynchronous reset, active low.
  input wire logic POWER_GOOD, // Supplies in range, asynchronous.
  input wire logic TCK, // Link clock, sampled.
  input wire logic TMS, // Link mode select.
  input wire logic TDI, // Link data in.
  output logic TDO, // Link data out.
  output logic TDO_OE, // Link data out enable.
  input wire logic [N_PINS-1:0] USER_O, // User design pin values.
  input wire logic [N_PINS-1:0] USER_OE, // User design pin enables.
  output logic [N_PINS-1:0] USER_PIN_I, // Synchronised pin levels.
  input wire logic [N_PINS-1:0] PIN_I, // Pin levels.
  output logic [N_PINS-1:0] PIN_O, // Pin output values.
  output logic [N_PINS-1:0] PIN_OE, // Pin output enables.
  output logic [N_PINS-1:0] PIN_PULLUP, // Weak pull-up enables.
  output logic [DW-1:0] CFG_IMAGE, // Running configuration word.
  output logic USER_RUN, // Configured and released.
  input wire logic UA_REQ, // User region access request.
  input wire logic UA_WE, // User region write.
  input wire logic [AW-2:0] UA_ADDR, // User region word address.
  input wire logic [DW-1:0] UA_WDATA, // User region write data.
  output logic [DW-1:0] UA_RDATA, // User region read data.
  output logic UA_ACK // Access done, one-cycle pulse.
);

  function automatic int maxi(input int a, input int b);
    maxi = (a > b) ? a : b;
  endfunction

  localparam int DR_W = maxi(maxi(32, 2 * N_PINS), maxi(AW, DW));
  localparam int CW = $clog2(CONFIG_CYCLES + 1);
  localparam logic [AW-1:0] FLAG_ADDR = {1'b0, {(AW-1){1'b1}}};

  initial
  begin
    if (CONFIG_CYCLES < 1 || N_PINS < 1 || AW < 2 || DW < 2)
      $error("isp_io_control: parameter out of range");
  end

  // ----------------------------------------------------------------
  // Synchronisers
  // ----------------------------------------------------------------
  logic [2:0] tck_sync_reg;
  logic [1:0] tms_sync_reg, tdi_sync_reg, pwr_sync_reg;
  logic [N_PINS-1:0] pin_sync_reg;

  always_ff @(posedge MCLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      tck_sync_reg <= '0;
      tms_sync_reg <= 2'h3;
      tdi_sync_reg <= '0;
      pwr_sync_reg <= '0;
      pin_sync_reg <= '0;
      USER_PIN_I <= '0;
    end
    else
    begin
      tck_sync_reg <= {tck_sync_reg[1:0], TCK};
      tms_sync_reg <= {tms_sync_reg[0], TMS};
      tdi_sync_reg <= {tdi_sync_reg[0], TDI};
      pwr_sync_reg <= {pwr_sync_reg[0], POWER_GOOD};
      pin_sync_reg <= PIN_I;
      USER_PIN_I <= pin_sync_reg;
    end
  end

  logic tck_rise, tck_fall, power_ok;
  assign tck_rise = tck_sync_reg[1] & ~tck_sync_reg[2];
  assign tck_fall = ~tck_sync_reg[1] & tck_sync_reg[2];
  assign power_ok = pwr_sync_reg[1];

  // ----------------------------------------------------------------
  // Link controller
  // ----------------------------------------------------------------
  function automatic tap_state_e tap_step(input tap_state_e s, input logic m);
    case (s)
      TAP_RESET: tap_step = m ? TAP_RESET : TAP_IDLE;
      TAP_IDLE, TAP_UPD_DR, TAP_UPD_IR: tap_step = m ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_DR: tap_step = m ? TAP_SEL_IR : TAP_CAP_DR;
      TAP_CAP_DR, TAP_SH_DR: tap_step = m ? TAP_EX1_DR : TAP_SH_DR;
      TAP_EX1_DR: tap_step = m ? TAP_UPD_DR : TAP_PA_DR;
      TAP_PA_DR: tap_step = m ? TAP_EX2_DR : TAP_PA_DR;
      TAP_EX2_DR: tap_step = m ? TAP_UPD_DR : TAP_SH_DR;
      TAP_SEL_IR: tap_step = m ? TAP_RESET : TAP_CAP_IR;
      TAP_CAP_IR, TAP_SH_IR: tap_step = m ? TAP_EX1_IR : TAP_SH_IR;
      TAP_EX1_IR: tap_step = m ? TAP_UPD_IR : TAP_PA_IR;
      TAP_PA_IR: tap_step = m ? TAP_EX2_IR : TAP_PA_IR;
      TAP_EX2_IR: tap_step = m ? TAP_UPD_IR : TAP_SH_IR;
      default: tap_step = TAP_RESET;
    endcase
  endfunction

  function automatic int dr_len(input logic [`IR_W-1:0] ins);
    case (ins)
      `INS_IDCODE: dr_len = 32;
      `INS_ADDRESS: dr_len = AW;
      `INS_PROGRAM, `INS_VERIFY: dr_len = DW;
      `INS_CLAMP: dr_len = 2 * N_PINS;
      default: dr_len = 1;
    endcase
  endfunction

  tap_state_e tap_reg, tap_next;
  logic [`IR_W-1:0] ir_reg, ir_shift_reg;
  logic [DR_W-1:0] dr_reg, dr_next;
  logic [AW-1:0] addr_reg;
  logic [DW-1:0] rdata;
  logic secure_reg, done_reg, run_done_reg;
  logic [2*N_PINS-1:0] clamp_code_reg;

  assign tap_next = tap_step(tap_reg, tms_sync_reg[1]);

  // Update-IR and the step into Run-Test-Idle share one edge, so the word being
  // updated must already count as the current instruction there.
  logic [`IR_W-1:0] ir_now;
  assign ir_now = (tap_reg == TAP_UPD_IR) ? ir_shift_reg : ir_reg;

  logic upd_ir, upd_dr, cap_dr, rti_enter, verify_hold;
  assign upd_ir = tck_rise && tap_reg == TAP_UPD_IR;
  assign upd_dr = tck_rise && tap_reg == TAP_UPD_DR;
  assign cap_dr = tck_rise && tap_reg == TAP_CAP_DR;
  assign rti_enter = tck_rise && tap_reg != TAP_IDLE && tap_next == TAP_IDLE;
  assign verify_hold = tap_reg == TAP_CAP_DR && ir_reg == `INS_VERIFY;

  // The volatile image has no path into the data register at all. // R13
  always_comb
  begin
    dr_next = dr_reg >> 1;
    dr_next[dr_len(ir_reg)-1] = tdi_sync_reg[1];
  end

  always_ff @(posedge MCLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      tap_reg <= TAP_RESET;
      ir_reg <= `INS_IDCODE;
      ir_shift_reg <= '0;
      dr_reg <= '0;
      addr_reg <= '0;
    end
    else if (tck_rise)
    begin
      tap_reg <= tap_next;
      if (tap_reg == TAP_RESET)
        ir_reg <= `INS_IDCODE;
      if (tap_reg == TAP_CAP_IR)
        ir_shift_reg <= `IR_CAPTURE;
      if (tap_reg == TAP_SH_IR)
        ir_shift_reg <= {tdi_sync_reg[1], ir_shift_reg[`IR_W-1:1]};
      if (tap_reg == TAP_UPD_IR)
        ir_reg <= ir_shift_reg;
      if (tap_reg == TAP_SH_DR)
        dr_reg <= dr_next;
      if (tap_reg == TAP_CAP_DR)
      begin
        dr_reg <= '0;
        case (ir_reg)
          `INS_IDCODE: dr_reg[31:0] <= `DEVICE_ID;
          `INS_CLAMP: dr_reg[2*N_PINS-1:0] <= clamp_code_reg;
          // User region stays readable whatever the security bit. // R14
          `INS_VERIFY: if (addr_reg[AW-1] || !secure_reg) dr_reg[DW-1:0] <= rdata; // R11
          default: dr_reg <= '0;
        endcase
      end
      if (tap_reg == TAP_UPD_DR && ir_reg == `INS_ADDRESS)
        addr_reg <= dr_reg[AW-1:0];
    end
  end

  // Data leaves on the falling link edge so the host samples it settled.
  always_ff @(posedge MCLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      TDO <= 1'b0;
      TDO_OE <= 1'b0;
    end
    else if (tck_fall)
    begin
      TDO <= (tap_reg == TAP_SH_IR) ? ir_shift_reg[0] : dr_reg[0];
      TDO_OE <= tap_reg == TAP_SH_IR || tap_reg == TAP_SH_DR;
    end
  end

  // ----------------------------------------------------------------
  // ISP mode and per-pin clamp
  // ----------------------------------------------------------------
  boot_state_e boot_reg;
  logic configured, isp_reg, rt_reg, clamp_en_reg, erase_busy_reg;
  logic [N_PINS-1:0] hold_o_reg, hold_oe_reg;
  logic reload_req;
  assign configured = boot_reg == BOOT_RUN;

  assign reload_req = isp_reg && !erase_busy_reg &&
    ((rti_enter && ir_now == `INS_RECONFIG) || // R9
     (upd_ir && ir_shift_reg == `INS_EXIT && !rt_reg));

  always_ff @(posedge MCLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      isp_reg <= 1'b0;
      rt_reg <= 1'b0;
      clamp_en_reg <= 1'b0;
      clamp_code_reg <= '0;
      hold_o_reg <= '0;
      hold_oe_reg <= '0;
    end
    else if (!configured || reload_req)
    begin
      isp_reg <= 1'b0;
      rt_reg <= 1'b0;
      clamp_en_reg <= 1'b0;
    end
    else if (upd_ir && ir_shift_reg == `INS_ENTER)
    begin
      isp_reg <= 1'b1;
      rt_reg <= 1'b0;
      clamp_en_reg <= 1'b0;
    end
    else if (upd_ir && ir_shift_reg == `INS_ENTER_RT)
    begin
      isp_reg <= 1'b1;
      rt_reg <= 1'b1;
      clamp_en_reg <= 1'b0;
    end
    else if (upd_ir && ir_shift_reg == `INS_EXIT)
    begin
      isp_reg <= 1'b0;
      rt_reg <= 1'b0;
      clamp_en_reg <= 1'b0;
    end
    else if (upd_dr && ir_reg == `INS_CLAMP)
    begin
      isp_reg <= 1'b1;
      rt_reg <= 1'b0;
      clamp_en_reg <= 1'b1;
      clamp_code_reg <= dr_reg[2*N_PINS-1:0]; // R6
      hold_o_reg <= USER_O; // R4
      hold_oe_reg <= USER_OE;
    end
  end

  // ----------------------------------------------------------------
  // Erase, program and flags
  // ----------------------------------------------------------------
  logic erase_ufm_reg;
  logic [AW-2:0] erase_ptr_reg;
  logic erase_go, flag_wr, prog_wr, isp_ok;
  logic [CW-1:0] boot_cnt_reg;
  logic flag_load;
  assign flag_load = boot_reg == BOOT_WAIT && boot_cnt_reg == '0;
  assign isp_ok = isp_reg && configured && !erase_busy_reg;
  assign erase_go = rti_enter && isp_ok &&
    (ir_now == `INS_ERASE_CFG || ir_now == `INS_ERASE_UFM);
  assign flag_wr = rti_enter && isp_ok &&
    (ir_now == `INS_SECURE || ir_now == `INS_DONE);
  // Writes reach only the addressed region; the flag word is off limits. // R1
  assign prog_wr = upd_dr && isp_ok && ir_reg == `INS_PROGRAM && addr_reg != FLAG_ADDR;

  always_ff @(posedge MCLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      erase_busy_reg <= 1'b0;
      erase_ufm_reg <= 1'b0;
      erase_ptr_reg <= '0;
    end
    else if (erase_go)
    begin
      erase_busy_reg <= 1'b1;
      erase_ufm_reg <= ir_now == `INS_ERASE_UFM;
      erase_ptr_reg <= '0;
    end
    else if (erase_busy_reg)
    begin
      erase_ptr_reg <= erase_ptr_reg + 1'b1;
      if (&erase_ptr_reg)
        erase_busy_reg <= 1'b0;
    end
  end

  always_ff @(posedge MCLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      secure_reg <= 1'b1;
      done_reg <= 1'b0;
    end
    else if (flag_load)
    begin
      secure_reg <= rdata[`FLAG_SECURE_BIT];
      done_reg <= rdata[`FLAG_DONE_BIT];
    end
    else if (erase_go && ir_now == `INS_ERASE_CFG)
    begin
      secure_reg <= 1'b0; // R12
      done_reg <= 1'b0;
    end
    else if (flag_wr)
    begin
      secure_reg <= secure_reg | (ir_now == `INS_SECURE);
      done_reg <= done_reg | (ir_now == `INS_DONE);
    end
  end

  // ----------------------------------------------------------------
  // Flash access arbitration
  // ----------------------------------------------------------------
  logic mem_we, ua_grant;
  logic [AW-1:0] mem_addr;
  logic [DW-1:0] mem_wdata;

  always_comb
  begin
    mem_we = 1'b0;
    mem_wdata = '0;
    ua_grant = 1'b0;
    mem_addr = addr_reg;
    if (boot_reg == BOOT_IMG)
      mem_addr = '0;
    else if (boot_reg == BOOT_FLAG)
      mem_addr = FLAG_ADDR;
    else if (erase_busy_reg)
    begin
      mem_we = 1'b1;
      mem_addr = {erase_ufm_reg, erase_ptr_reg};
    end
    else if (flag_wr)
    begin
      mem_we = 1'b1;
      mem_addr = FLAG_ADDR;
      mem_wdata[`FLAG_SECURE_BIT] = secure_reg | (ir_now == `INS_SECURE);
      mem_wdata[`FLAG_DONE_BIT] = done_reg | (ir_now == `INS_DONE);
    end
    else if (prog_wr)
    begin
      mem_we = 1'b1;
      mem_wdata = dr_reg[DW-1:0];
    end
    // A request still held in its acknowledge cycle is not taken a second time.
    else if (!verify_hold && UA_REQ && configured && !UA_ACK)
    begin
      ua_grant = 1'b1; // R14
      mem_we = UA_WE;
      mem_addr = {1'b1, UA_ADDR};
      mem_wdata = UA_WDATA;
    end
  end

  flash_store #(.AW(AW), .DW(DW)) u_store (
    .clk(MCLK),
    .rst_n(RST_N),
    .we(mem_we),
    .addr(mem_addr),
    .wdata(mem_wdata),
    .rdata(rdata)
  );

  assign UA_RDATA = rdata;

  always_ff @(posedge MCLK or negedge RST_N)
  begin
    if (!RST_N)
      UA_ACK <= 1'b0;
    else
      UA_ACK <= ua_grant;
  end

  // ----------------------------------------------------------------
  // Boot and reload
  // ----------------------------------------------------------------
  always_ff @(posedge MCLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      boot_reg <= BOOT_OFF;
      boot_cnt_reg <= '0;
      CFG_IMAGE <= '0;
      run_done_reg <= 1'b0;
    end
    else if (!power_ok)
      boot_reg <= BOOT_OFF;
    else
      case (boot_reg)
        BOOT_OFF: boot_reg <= BOOT_IMG;
        BOOT_IMG: boot_reg <= BOOT_FLAG;
        BOOT_FLAG:
        begin
          CFG_IMAGE <= rdata; // R8
          boot_cnt_reg <= '0;
          boot_reg <= BOOT_WAIT;
        end
        BOOT_WAIT:
        begin
          if (boot_cnt_reg == '0)
            run_done_reg <= rdata[`FLAG_DONE_BIT];
          boot_cnt_reg <= boot_cnt_reg + 1'b1;
          if (boot_cnt_reg == CW'(CONFIG_CYCLES - 1))
            boot_reg <= BOOT_RUN;
        end
        BOOT_RUN: if (reload_req) boot_reg <= BOOT_IMG; // R9
        default: boot_reg <= BOOT_OFF;
      endcase
  end

  // ----------------------------------------------------------------
  // Pin drivers
  // ----------------------------------------------------------------
  always_ff @(posedge MCLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      PIN_O <= '0;
      PIN_OE <= '0;
      PIN_PULLUP <= '1;
      USER_RUN <= 1'b0;
    end
    else
    begin
      USER_RUN <= configured && run_done_reg && !(isp_reg && !rt_reg);
      for (int i = 0; i < N_PINS; i++)
      begin
        PIN_O[i] <= 1'b0;
        PIN_OE[i] <= 1'b0;
        PIN_PULLUP[i] <= 1'b1;
        if (!configured)
          PIN_OE[i] <= 1'b0; // R10 R15
        else if (isp_reg && !rt_reg && clamp_en_reg)
          case (clamp_code_reg[2*i +: 2])
            `CLAMP_HOLD:
            begin
              PIN_O[i] <= hold_o_reg[i];
              PIN_OE[i] <= hold_oe_reg[i]; // R5
              PIN_PULLUP[i] <= !hold_oe_reg[i];
            end
            `CLAMP_HIGH:
            begin
              PIN_O[i] <= 1'b1; // R4
              PIN_OE[i] <= 1'b1;
              PIN_PULLUP[i] <= 1'b0;
            end
            `CLAMP_LOW:
            begin
              PIN_OE[i] <= 1'b1;
              PIN_PULLUP[i] <= 1'b0;
            end
            default: PIN_OE[i] <= 1'b0;
          endcase
        else if (isp_reg && !rt_reg)
          PIN_OE[i] <= 1'b0; // R3
        else if (run_done_reg)
        begin
          PIN_O[i] <= USER_O[i]; // R7
          PIN_OE[i] <= USER_OE[i];
          PIN_PULLUP[i] <= 1'b0;
        end
        else
          PIN_OE[i] <= 1'b0; // R16
      end
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking @(posedge MCLK); endclocking
  default disable iff (!RST_N);

  sequence s_reload;
    configured && reload_req;
  endsequence
  sequence s_pins_quiet;
    PIN_OE == '0 && PIN_PULLUP == '1;
  endsequence

  AST_UNCONFIG_QUIET: assert property (!configured |=> PIN_OE == '0) // R15
    else $error("pin driven before configuration");
  AST_DONE_GATE: assert property (configured && !isp_reg && !run_done_reg |=> PIN_OE == '0) // R16
    else $error("pin driven without complete flag");
  AST_ISP_TRI: assert property (configured && isp_reg && !rt_reg && !clamp_en_reg
    |=> s_pins_quiet) // R3
    else $error("pins not released during ISP");
  AST_CLAMP_HIGH0: assert property (configured && isp_reg && !rt_reg && clamp_en_reg &&
    clamp_code_reg[1:0] == `CLAMP_HIGH |=> PIN_OE[0] && PIN_O[0]) // R4
    else $error("clamp high not applied");
  AST_HOLD_INPUT: assert property (configured && isp_reg && clamp_en_reg && !rt_reg &&
    clamp_code_reg[1:0] == `CLAMP_HOLD && !hold_oe_reg[0] |=> !PIN_OE[0]) // R5
    else $error("held input pin driven");
  AST_RT_RUN: assert property (configured && isp_reg && rt_reg && run_done_reg
    |=> PIN_OE == $past(USER_OE) && PIN_O == $past(USER_O)) // R7
    else $error("real-time mode disturbed user pins");
  AST_IMAGE_KEEP: assert property (configured && $past(configured) |-> $stable(CFG_IMAGE)) // R8
    else $error("running image changed without boot");
  AST_RELOAD_QUIET: assert property (s_reload |=> ##1 s_pins_quiet [*8]) // R10
    else $error("pins active during reload");
  AST_SECURE_READ: assert property (cap_dr && ir_reg == `INS_VERIFY && secure_reg &&
    !addr_reg[AW-1] |=> dr_reg == '0) // R11
    else $error("secured config data read back");
  AST_SECURE_STICK: assert property ($fell(secure_reg) |-> $past(erase_go) || $past(flag_load)) // R12
    else $error("security bit cleared without erase");
  AST_UA_ONCE: assert property (UA_ACK |=> !UA_ACK) // R14
    else $error("user access acknowledged twice");

endmodule

// ===== isp_host_model.sv
// JTAG programming host model: drives the link pins and shifts IR and DR scans.
// Assumes the device samples TCK with its own clock; TCK stays low between scans.
`timescale 1ns/1ps
module isp_host_model (
  input wire logic TDO, // Link data from the device.
  output logic TCK, // Link clock, 80 ns period.
  output logic TMS, // Link mode select.
  output logic TDI // Link data to the device.
);
  logic [31:0] dout; // Bits shifted out by the last scan.
  logic tdo_s; // TDO seen at the last TCK rise.
  event scanned;

  initial
  begin
    TCK = 1'b0;
    TMS = 1'b1;
    TDI = 1'b0;
  end

  // Outside a shift TDI is toggled, so a released data line never shows a stale bit.
  task automatic tck1(input logic ms, input logic di);
    TMS = ms;
    TDI = di;
    #40 TCK = 1'b1;
    tdo_s = TDO;
    #40 TCK = 1'b0;
  endtask

  task automatic idle(input int n);
    repeat (n) tck1(1'b0, ~TDI);
  endtask

  task automatic reset_tap();
    repeat (5) tck1(1'b1, ~TDI);
    tck1(1'b0, ~TDI);
  endtask

  task automatic scan(input logic ir, input logic [31:0] din, input int n);
    logic [31:0] d;
    d = '0;
    tck1(1'b1, ~TDI);
    if (ir)
      tck1(1'b1, ~TDI);
    repeat (2) tck1(1'b0, ~TDI);
    for (int i = 0; i < n; i++)
    begin
      tck1(i == n - 1, din[i]);
      d[i] = tdo_s;
    end
    tck1(1'b1, ~TDI);
    tck1(1'b0, ~TDI);
    dout = d;
    -> scanned;
  endtask
endmodule

// ===== tb_isp_io_control.sv
// Self-checking bench for the ISP pin-control block.
// Assumes isp_host_model drives the link; the configuration time is cut to 20 cycles.
`include "isp_map.svh"
`timescale 1ns/1ps
module tb_isp_io_control;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] uo = 8'h00;
  logic [7:0] uoe = 8'h5b;
  logic [7:0] pin_i = 8'h00;
  logic ua_req = 1'b0;
  logic ua_we = 1'b0;
  logic [4:0] ua_addr = 5'h00;
  logic [15:0] ua_wd = 16'h0000;
  logic tck, tms, tdi, tdo, tdo_oe, run, ua_ack;
  logic pg = 1'b1;
  logic [7:0] pin_o, pin_oe, pin_pu, upi;
  logic [15:0] cfg, ua_rd;
  logic [31:0] seed = 32'd56799;
  logic [31:0] img, img2, ud, h, hb;
  logic [32:0] dr_q[$];
  logic [32:0] sq;
  logic [31:0] ua_q[$];
  int error_cnt = 0;
  int comparisons = 0;

  always #5 mclk = ~mclk;

  isp_host_model host (.TDO(tdo), .TCK(tck), .TMS(tms), .TDI(tdi));

  isp_io_control #(.CONFIG_CYCLES(20)) dut (
    .MCLK(mclk), .RST_N(rst_n), .POWER_GOOD(pg), .TCK(tck), .TMS(tms), .TDI(tdi),
    .TDO(tdo), .TDO_OE(tdo_oe), .USER_O(uo), .USER_OE(uoe), .USER_PIN_I(upi), .PIN_I(pin_i),
    .PIN_O(pin_o), .PIN_OE(pin_oe), .PIN_PULLUP(pin_pu), .CFG_IMAGE(cfg), .USER_RUN(run),
    .UA_REQ(ua_req), .UA_WE(ua_we), .UA_ADDR(ua_addr), .UA_WDATA(ua_wd), .UA_RDATA(ua_rd),
    .UA_ACK(ua_ack));

  // ----------------------------------------
  // Checking
  // ----------------------------------------
  task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp, input string what);
    comparisons++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic cmp_pins(input logic [7:0] eoe, input logic [7:0] eo);
    cmp_word({16'h0, pin_oe, pin_o & eoe}, {16'h0, eoe, eo & eoe}, "pins");
  endtask

  task automatic end_of_test();
    if (error_cnt == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // Every scan leaves one note, so a scan started before this process wakes cannot steal it.
  always @(host.scanned)
  begin
    sq = dr_q.pop_front();
    if (sq[32])
      cmp_word(host.dout, sq[31:0], "scan");
  end

  always @(posedge mclk)
    if (ua_ack === 1'b1 && ua_we === 1'b0)
      cmp_word(32'(ua_rd), ua_q.pop_front(), "user read");

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic settle(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  task automatic ins(input logic [3:0] c);
    dr_q.push_back({1'b1, 32'(`IR_CAPTURE)});
    host.scan(1'b1, 32'(c), `IR_W);
  endtask

  task automatic dr(input logic [31:0] v, input int n, input logic c, input logic [31:0] e);
    dr_q.push_back({c, e});
    host.scan(1'b0, v, n);
  endtask

  task automatic prog(input logic [5:0] a, input logic [31:0] d);
    ins(`INS_ADDRESS);
    dr(32'(a), 6, 1'b0, 0);
    ins(`INS_PROGRAM);
    dr(d, 16, 1'b0, 0);
    host.idle(2);
  endtask

  task automatic ver(input logic [5:0] a, input logic [31:0] e);
    ins(`INS_ADDRESS);
    dr(32'(a), 6, 1'b0, 0);
    ins(`INS_VERIFY);
    dr(0, 16, 1'b1, e);
  endtask

  task automatic quiet();
    cmp_pins(8'h00, 8'h00);
    cmp_word(32'(pin_pu), 32'hff, "pullup");
  endtask

  task automatic ua(input logic we, input logic [4:0] a, input logic [15:0] d);
    int k;
    k = 0;
    if (!we)
      ua_q.push_back(32'(d));
    ua_req = 1'b1;
    ua_we = we;
    ua_addr = a;
    ua_wd = d;
    do @(posedge mclk); while (ua_ack !== 1'b1 && ++k < 30);
    #1 ua_req = 1'b0;
  endtask

  initial
  begin
    #400us;
    error_cnt++;
    end_of_test();
  end

  initial
  begin
    pin_i = 8'(rnd());
    uo = 8'(rnd());
    img = rnd() & 32'hffff;
    img2 = rnd() & 32'hffff;
    ud = rnd() & 32'hffff;
    settle(4);
    rst_n = 1'b1;
    settle(8);
    quiet();
    settle(40);
    host.reset_tap();
    ins(`INS_ENTER);
    quiet();
    ins(`INS_IDCODE);
    dr(0, 32, 1'b1, `DEVICE_ID);
    ins(`INS_ERASE_CFG);
    host.idle(8);
    ins(`INS_ERASE_UFM);
    host.idle(8);
    prog(6'h00, img);
    prog(6'h23, ud);
    ver(6'h00, img);
    ver(6'h23, ud);
    ins(`INS_DONE);
    ins(`INS_EXIT);
    settle(12);
    quiet();
    settle(30);
    cmp_word({run, cfg}, {1'b1, img[15:0]}, "image");
    cmp_pins(uoe, uo);
    cmp_word(32'(upi), 32'(pin_i), "pin input");
    cmp_word(32'(tdo_oe), 32'h0, "link enable");
    ua(1'b0, 5'h03, ud[15:0]);
    h = rnd() & 32'hffff;
    ua(1'b1, 5'h04, h[15:0]);
    ua(1'b0, 5'h04, h[15:0]);
    uoe = 8'h0f;
    hb = 32'(uo[0]);
    ins(`INS_CLAMP);
    dr(32'he4e4, 16, 1'b0, 0);
    settle(2);
    uo = ~uo;
    uoe = 8'(rnd());
    settle(3);
    cmp_pins(8'h67, 8'h22 | hb[7:0]);
    ins(`INS_SECURE);
    ver(6'h00, 0);
    ver(6'h24, 32'(h[15:0]));
    ins(`INS_ERASE_UFM);
    host.idle(8);
    ins(`INS_DONE);
    ver(6'h00, 0);
    ins(`INS_ERASE_CFG);
    host.idle(8);
    prog(6'h00, img);
    ver(6'h00, img);
    ins(`INS_DONE);
    ins(`INS_EXIT);
    settle(45);
    ins(`INS_ENTER_RT);
    cmp_pins(uoe, uo);
    prog(6'h00, img2);
    ins(`INS_EXIT);
    settle(30);
    cmp_word({run, cfg}, {1'b1, img[15:0]}, "image");
    ins(`INS_ENTER_RT);
    ins(`INS_RECONFIG);
    settle(12);
    quiet();
    settle(30);
    cmp_word({run, cfg}, {1'b1, img2[15:0]}, "image");
    pg = 1'b0;
    settle(6);
    quiet();
    pg = 1'b1;
    settle(35);
    cmp_word({run, cfg}, {1'b1, img2[15:0]}, "image");
    end_of_test();
  end
endmodule
